// >>> eeprom_slave_pkg.sv
// shared constants and types for the two-wire eeprom slave port
package eeprom_slave_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_MHZ       = 125;   // sys_clk rate in MHz
    localparam int WRITE_TIME_US = 3000;  // longest self-timed write, us
    // longest time as a whole number of sys_clk cycles
    localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;
    localparam int TIMER_W       = 19;    // wide enough for the count

    // ****************************************************************
    // array organisation
    // ****************************************************************
    localparam int PAGE_COUNT  = 1024;
    localparam int PAGE_BYTES  = 256;
    localparam int ARRAY_BYTES = PAGE_COUNT * PAGE_BYTES;
    localparam int ADDR_W      = 18;      // byte address width
    localparam int PAGE_W      = 10;      // page number width
    localparam int UID_BYTES   = 16;      // 128-bit unique id

    // ****************************************************************
    // address byte fields and type prefixes
    // ****************************************************************
    localparam logic [3:0] TYPE_ARRAY = 4'ha;  // main array
    localparam logic [3:0] TYPE_EXTRA = 4'hb;  // id page, lock, protect, uid
    localparam int         STRAP_BIT  = 3;     // chip select bit position
    localparam int         RW_BIT     = 0;     // read = 1, write = 0

    // selector byte after a type-b address byte
    localparam logic [7:0] SEL_ID   = 8'h00;
    localparam logic [7:0] SEL_LOCK = 8'h04;
    localparam logic [7:0] SEL_PROT = 8'h08;
    localparam logic [7:0] SEL_UID  = 8'h0c;

    // block_protect_setting encodings
    localparam logic [1:0] PROT_NONE    = 2'h0;
    localparam logic [1:0] PROT_QUARTER = 2'h1;  // top quarter
    localparam logic [1:0] PROT_HALF    = 2'h2;  // top half
    localparam logic [1:0] PROT_ALL     = 2'h3;

    // ****************************************************************
    // bit counting and buffering
    // ****************************************************************
    localparam logic [3:0] BIT_LAST = 4'h7;  // eighth data bit
    localparam logic [3:0] BIT_ACK  = 4'h8;  // ninth clock
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 16;          // {page offset, data}

    typedef enum {
        ST_IDLE, ST_ADDR, ST_WORD_HI, ST_WORD_LO,
        ST_WRITE, ST_READ, ST_IGNORE
    } phase_type;

    typedef enum {
        TGT_ARRAY, TGT_ID, TGT_LOCK, TGT_PROT, TGT_UID
    } target_type;

endpackage

// >>> pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int         WIDTH     = 1,
    parameter logic [0:0] RESET_VAL = 1'h1
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pin,
    output var  logic [WIDTH-1:0] level
);

    logic [WIDTH-1:0] stage1;  // metastable stage, read by stage2 only
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // ****************************************************************
    // sampling chain
    // ****************************************************************
    // a change counts once the second and third stages agree, which
    // also swallows a single-sample glitch
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : bits
            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    stage1[g] <= RESET_VAL;
                    stage2[g] <= RESET_VAL;
                    stage3[g] <= RESET_VAL;
                    level[g]  <= RESET_VAL;
                end else begin
                    stage1[g] <= pin[g];
                    stage2[g] <= stage1[g];
                    stage3[g] <= stage2[g];
                    if (stage2[g] == stage3[g]) begin
                        level[g] <= stage3[g];
                    end
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// >>> byte_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);

    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];  // word storage
    logic [PTR_W-1:0] wr_ptr;             // next slot to fill
    logic [PTR_W-1:0] rd_ptr;             // oldest word
    logic [PTR_W:0]   fill;               // words held
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    assign in_ready  = (fill != (PTR_W+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign out_data  = store[rd_ptr];

    // ****************************************************************
    // pointers and count
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            // push and pop together leave the count alone
            fill <= fill + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

    // storage is not reset; only filled slots are ever read
    always_ff @(posedge sys_clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

endmodule
`default_nettype wire

// >>> serial_eeprom_slave_port.sv
// two-wire slave port of a page-organised serial eeprom
//
// Summary of operation
// R1: sample on rising scl, drive on falling
// R2: write-protect high makes array read-only
// R3: write-protect high: ack addresses, nack data
// R4: write-protect low lets writes proceed
// R5: array is 1024 pages of 256 bytes
// R6: byte or partial page writes up to 256
// R7: self-timed programming within three milliseconds
// R8: block protect covers quarter, half or all
// R9: id page writable until permanently locked
// R10: 128-bit unique id is read-only
// R11: type 1010 array, 1011 extra spaces
// R12: ack matching address, else standby; lsb rw
// R13: nine clocks per byte, msb first, ack
// R14: stop after write starts programming, else standby
// R15: no address ack while programming runs
// R16: address advances, write wraps within page
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_slave_port
    import eeprom_slave_pkg::*;
#(
    parameter int               WRITE_COUNT = WRITE_CYCLES,
    parameter logic [8*UID_BYTES-1:0] UID_VALUE =
        128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210  // arbitrary value
) (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic scl,                // link clock from the master
    input  wire logic sda_in,
    output var  logic sda_out,
    output var  logic sda_oe_n,           // low while pulling sda low
    input  wire logic write_protect,
    input  wire logic chip_select_strap,
    output var  logic write_busy
);

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [7:0] array_mem [0:ARRAY_BYTES-1];  // main array R5
    logic [7:0] id_page   [0:PAGE_BYTES-1];   // identification page
    logic [7:0] page_latch[0:PAGE_BYTES-1];   // bytes awaiting commit
    logic [PAGE_BYTES-1:0] latch_mask;        // which latch bytes are new
    // non-volatile settings keep their value through reset_n
    logic       id_locked            = 1'b0;
    logic [1:0] block_protect_setting = PROT_NONE;
    logic [7:0] pending_ctl;                  // last protect/lock byte

    // ****************************************************************
    // control state
    // ****************************************************************
    phase_type          phase;
    target_type         target;
    logic [3:0]         bit_cnt;      // bit within the nine-clock byte
    logic [ADDR_W-1:0]  byte_addr;    // internal address pointer
    logic [PAGE_W-1:0]  wr_page;      // page under write
    logic               extra_space;  // address byte used type b
    logic               got_data;     // a data byte was accepted
    logic               rd_first;     // first byte of a read
    logic               tx_release;   // next bit: 1 release, 0 low
    logic [7:0]         rd_byte;      // byte being shifted out
    logic               link_enable;  // driver allowed onto sda
    logic [TIMER_W-1:0] timer;        // programming time counter
    logic               scl_d;
    logic               sda_d;

    // link domain
    logic [7:0] rx_shift;             // captured bits, msb first
    logic       link_drive_n = 1'b1;  // driver flop on falling scl

    // synchronised pins
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic strap_s;

    pin_sync #(
        .WIDTH     (2),
        .RESET_VAL (1'h1)
    ) bus_sync (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .pin     ({scl, sda_in}),
        .level   ({scl_s, sda_s})
    );

    // straps idle low, as the pins are pulled down when floating
    pin_sync #(
        .WIDTH     (2),
        .RESET_VAL (1'h0)
    ) strap_sync (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .pin     ({write_protect, chip_select_strap}),
        .level   ({wp_s, strap_s})
    );

    // ****************************************************************
    // link clock domain
    // ****************************************************************
    // bits are taken on rising scl R1
    always_ff @(posedge scl) begin
        rx_shift <= {rx_shift[6:0], sda_in};  // R13
    end

    // the pin only ever changes on falling scl; tx_release is settled
    // long before, since it moves right after the rising edge R1
    always_ff @(negedge scl) begin
        link_drive_n <= tx_release;  // R1
    end

    assign sda_out  = 1'b0;  // open drain: only ever pulls low
    assign sda_oe_n = link_drive_n | ~link_enable;

    // ****************************************************************
    // bus events and decode
    // ****************************************************************
    wire scl_rise   = scl_s & ~scl_d;
    wire start_seen = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_seen  = scl_s & scl_d & ~sda_d & sda_s;
    wire byte_done  = scl_rise & (bit_cnt == BIT_LAST);
    wire ack_done   = scl_rise & (bit_cnt == BIT_ACK);

    // rx_shift is stable from its last rising scl until the next one,
    // so reading it a few cycles after the synced edge is safe
    wire [7:0] rx_byte   = rx_shift;
    wire [3:0] rx_type   = rx_byte[7:4];
    wire       type_hit  = (rx_type == TYPE_ARRAY)
                         | (rx_type == TYPE_EXTRA);               // R11
    wire       addr_hit  = type_hit & (rx_byte[STRAP_BIT] == strap_s)
                         & ~write_busy;                           // R12 R15
    wire [7:0] offset    = byte_addr[7:0];

    // selector byte to target space
    function automatic target_type pick_target(input logic [7:0] sel);
        if (sel == SEL_ID) begin
            pick_target = TGT_ID;
        end else if (sel == SEL_LOCK) begin
            pick_target = TGT_LOCK;
        end else if (sel == SEL_PROT) begin
            pick_target = TGT_PROT;
        end else begin
            pick_target = TGT_UID;
        end
    endfunction

    // whether a data byte to this place may be written
    function automatic logic may_write(input target_type tg,
                                       input logic [ADDR_W-1:0] a);
        logic blocked;
        blocked = 1'b0;
        case (block_protect_setting)  // R8
            PROT_QUARTER: blocked = (a[ADDR_W-1 -: 2] == 2'h3);
            PROT_HALF:    blocked = a[ADDR_W-1];
            PROT_ALL:     blocked = 1'b1;
            default:      blocked = 1'b0;
        endcase
        case (tg)
            TGT_ARRAY: may_write = ~wp_s & ~blocked;   // R2 R4
            TGT_ID:    may_write = ~wp_s & ~id_locked; // R9
            TGT_LOCK:  may_write = ~wp_s & ~id_locked; // R9
            TGT_PROT:  may_write = ~wp_s;
            default:   may_write = 1'b0;               // R10
        endcase
    endfunction

    // byte presented to the master for a given place
    function automatic logic [7:0] read_byte(input target_type tg,
                                             input logic [ADDR_W-1:0] a);
        case (tg)
            TGT_ARRAY: read_byte = array_mem[a];
            TGT_ID:    read_byte = id_page[a[7:0]];
            TGT_LOCK:  read_byte = {7'h00, id_locked};
            TGT_PROT:  read_byte = {6'h00, block_protect_setting};
            default:   read_byte = UID_VALUE[8*(UID_BYTES-1-a[3:0]) +: 8];
        endcase
    endfunction

    logic [7:0] rd_now;
    logic       wr_ok;
    // a wire would miss changes of the settings the functions read
    always_comb begin
        rd_now = read_byte(target, byte_addr);
        wr_ok  = may_write(target, byte_addr);
    end
    wire       drain_ok;
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [FIFO_WIDTH-1:0] fifo_out_data;
    wire       commit_now = write_busy
                          & (timer == TIMER_W'(WRITE_COUNT - 1))
                          & ~fifo_out_valid;
    wire       accept_data = byte_done & (phase == ST_WRITE)
                           & wr_ok & fifo_in_ready;               // R3
    assign drain_ok = ~commit_now;

    // incoming data bytes queue here; a full queue refuses the byte
    byte_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) data_fifo (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .in_valid  (accept_data),
        .in_ready  (fifo_in_ready),
        .in_data   ({offset, rx_byte}),
        .out_valid (fifo_out_valid),
        .out_ready (drain_ok),
        .out_data  (fifo_out_data)
    );

    // ****************************************************************
    // protocol engine
    // ****************************************************************
    // start and stop take priority over any bit in flight
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            phase       <= ST_IDLE;
            target      <= TGT_ARRAY;
            bit_cnt     <= 4'h0;
            byte_addr   <= '0;
            wr_page     <= '0;
            extra_space <= 1'b0;
            got_data    <= 1'b0;
            rd_first    <= 1'b0;
            tx_release  <= 1'b1;
            rd_byte     <= 8'h00;
            link_enable <= 1'b0;
            scl_d       <= 1'b1;
            sda_d       <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            if (start_seen) begin
                // repeated start keeps the address for random reads
                phase       <= ST_ADDR;
                bit_cnt     <= 4'h0;
                got_data    <= 1'b0;
                tx_release  <= 1'b1;
                link_enable <= 1'b1;
            end else if (stop_seen) begin
                phase      <= ST_IDLE;  // R14
                got_data   <= 1'b0;
                tx_release <= 1'b1;
            end else if (ack_done) begin
                bit_cnt    <= 4'h0;  // R13
                tx_release <= 1'b1;
                if (phase == ST_READ) begin
                    // master nack ends the read; ack fetches the next
                    if (rd_first | ~sda_s) begin
                        rd_first   <= 1'b0;
                        rd_byte    <= rd_now;
                        tx_release <= rd_now[7];  // R13
                    end else begin
                        phase <= ST_IGNORE;
                    end
                end
            end else if (byte_done) begin
                bit_cnt    <= BIT_ACK;
                tx_release <= 1'b0;  // ack unless a branch refuses
                case (phase)
                    ST_ADDR: begin
                        if (addr_hit) begin  // R12
                            extra_space <= (rx_type == TYPE_EXTRA);
                            if (rx_type == TYPE_ARRAY) begin
                                target <= TGT_ARRAY;
                                byte_addr[ADDR_W-1 -: 2] <= rx_byte[2:1];
                            end
                            if (rx_byte[RW_BIT]) begin
                                phase    <= ST_READ;
                                rd_first <= 1'b1;
                            end else begin
                                phase <= ST_WORD_HI;
                            end
                        end else begin
                            tx_release <= 1'b1;  // R12 R15
                            phase      <= ST_IGNORE;
                        end
                    end
                    ST_WORD_HI: begin
                        phase <= ST_WORD_LO;  // R3
                        if (extra_space) begin
                            target <= pick_target(rx_byte);  // R11
                        end else begin
                            byte_addr[15:8] <= rx_byte;
                        end
                    end
                    ST_WORD_LO: begin
                        phase          <= ST_WRITE;  // R3
                        byte_addr[7:0] <= rx_byte;
                        wr_page        <= byte_addr[ADDR_W-1:8];
                    end
                    ST_WRITE: begin
                        if (accept_data) begin
                            got_data       <= 1'b1;  // R6
                            byte_addr[7:0] <= offset + 8'h01;  // R16
                        end else begin
                            tx_release <= 1'b1;  // R2 R3 R9 R10
                        end
                    end
                    ST_READ: begin
                        tx_release <= 1'b1;  // master answers
                        byte_addr  <= byte_addr + 1'b1;  // R16
                    end
                    default: begin
                        tx_release <= 1'b1;
                        phase      <= ST_IGNORE;
                    end
                endcase
            end else if (scl_rise && phase != ST_IDLE
                         && phase != ST_IGNORE) begin
                bit_cnt <= bit_cnt + 4'h1;
                if (phase == ST_READ) begin
                    tx_release <= rd_byte[3'(6 - bit_cnt)];  // R13
                end
            end
        end
    end

    // ****************************************************************
    // self-timed programming
    // ****************************************************************
    // a stop that ends an accepted write starts the cycle; the timer
    // runs from sys_clk alone, with no scl needed R7
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            write_busy <= 1'b0;
            timer      <= '0;
        end else if (stop_seen && got_data && phase == ST_WRITE) begin
            write_busy <= 1'b1;  // R14
            timer      <= '0;
        end else if (write_busy) begin
            if (commit_now) begin
                write_busy <= 1'b0;  // R7
            end else if (timer != TIMER_W'(WRITE_COUNT - 1)) begin
                timer <= timer + 1'b1;
            end
        end
    end

    // drain queued bytes into the latch, then commit the marked bytes
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            latch_mask  <= '0;
            pending_ctl <= 8'h00;
        end else if (commit_now || (start_seen && !write_busy)) begin
            latch_mask <= '0;
        end else if (fifo_out_valid) begin
            latch_mask[fifo_out_data[15:8]] <= 1'b1;
            pending_ctl                     <= fifo_out_data[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (fifo_out_valid && drain_ok) begin
            page_latch[fifo_out_data[15:8]] <= fifo_out_data[7:0];
        end
    end

    // only bytes actually sent are written, so partial pages leave
    // the rest of the page untouched R6
    always_ff @(posedge sys_clk) begin
        if (commit_now) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (latch_mask[i] && target == TGT_ARRAY) begin
                    array_mem[{wr_page, 8'(i)}] <= page_latch[i];  // R5
                end
                if (latch_mask[i] && target == TGT_ID) begin
                    id_page[i] <= page_latch[i];  // R9
                end
            end
            if (target == TGT_LOCK && latch_mask != '0) begin
                id_locked <= 1'b1;  // R9
            end
            if (target == TGT_PROT && latch_mask != '0) begin
                block_protect_setting <= pending_ctl[1:0];  // R8
            end
        end
    end

endmodule
`default_nettype wire

// >>> serial_eeprom_slave_port_checker.sv
// assertions on the pins of the eeprom slave port
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_slave_port_checker #(
    parameter int WRITE_COUNT = 50
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic write_protect,
    input wire logic chip_select_strap,
    input wire logic write_busy
);
    int busy_cnt; // cycles spent programming so far
    always_ff @(posedge sys_clk) begin
        busy_cnt <= (reset_n && write_busy) ? busy_cnt + 1 : 0;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    AST_OD_LOW: assert property (sda_out == 1'b0)
        else $error("open drain value not low");
    AST_FALL_SCL_LOW: assert property ($fell(sda_oe_n) |-> !scl)
        else $error("sda pulled while scl high");
    AST_HOLD_SCL_HIGH: assert property (scl && $past(scl) |-> $stable(sda_oe_n))
        else $error("sda moved while scl high");
    AST_QUIET_BUSY: assert property (write_busy |-> sda_oe_n)
        else $error("answered while programming");
    AST_BUSY_MAX: assert property (write_busy |-> busy_cnt <= WRITE_COUNT)
        else $error("programming too long");
    AST_BUSY_LEN: assert property ($fell(write_busy) |-> busy_cnt >= WRITE_COUNT - 1)
        else $error("programming too short");
    AST_BUSY_STOP: assert property ($rose(write_busy) |-> scl && sda_in)
        else $error("programming began without stop");
    AST_WP_NO_PROG: assert property (write_protect && $past(write_protect, 8) |-> !$rose(write_busy))
        else $error("programming under write protect");
endmodule
`default_nettype wire

// >>> two_wire_master_model.sv
// two-wire bus master model with its own link tick
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model (
    output var logic scl,
    output var logic sda_low,
    input  wire logic sda
);
    logic tick = 1'b0; // 6 ns link tick, free of sys_clk phase
    always #3 tick = ~tick;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // ten ticks outlast the port's sensing
    task automatic hold();
        repeat (10) @(posedge tick);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        hold();
        scl = 1'b1;
        hold();
        r = sda;
        scl = 1'b0;
    endtask
    task automatic start();
        sda_low = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        sda_low = 1'b1;
        hold();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        hold();
        scl = 1'b1;
        hold();
        sda_low = 1'b0;
        hold();
    endtask
    // eight bits msb first then the answer clock
    task automatic xfer(input logic [7:0] d, input logic m9, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(m9, r);
        ack = !r;
    endtask
endmodule
`default_nettype wire

// >>> serial_eeprom_slave_port_bench.sv
// bench for the eeprom slave port driven by a two-wire master model
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_slave_port_bench import eeprom_slave_pkg::*;;
    localparam logic [127:0] UID = 128'h5a3c_0f96_1234_5678_9abc_def0_1357_2468; // arbitrary
    logic sys_clk = 1'b0, reset_n = 1'b0, write_protect = 1'b0, strap = 1'b0;
    logic scl, m_low, sda_out, sda_oe_n, write_busy, a;
    logic [7:0] q;
    int error_cnt = 0, checks_done = 0;
    wire sda = !m_low && (sda_oe_n || sda_out); // pulled-up open drain wire
    always #4 sys_clk = ~sys_clk;
    two_wire_master_model u_two_wire_master_model (.scl(scl), .sda_low(m_low), .sda(sda));
    serial_eeprom_slave_port #(.WRITE_COUNT(500), .UID_VALUE(UID)) u_serial_eeprom_slave_port (
        .sys_clk(sys_clk), .reset_n(reset_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .write_protect(write_protect),
        .chip_select_strap(strap), .write_busy(write_busy));
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic st(); u_two_wire_master_model.start(); endtask
    task automatic sp(); u_two_wire_master_model.stop(); endtask
    task automatic put(input logic [7:0] d, input logic ack);
        u_two_wire_master_model.xfer(d, 1'b1, q, a);
        check("ack", {7'h0, ack}, {7'h0, a});
    endtask
    // dummy write, restart, one read
    task automatic rd(input logic [7:0] dv, hi, lo, e);
        st(); put(dv, 1); put(hi, 1); put(lo, 1);
        st(); put(dv | 8'h01, 1);
        u_two_wire_master_model.xfer(8'hff, 1'b1, q, a);
        check("data", e, q);
        sp();
    endtask
    // three address bytes, one data byte
    task automatic wr(input logic [7:0] dv, hi, lo, d, input logic k);
        st(); put(dv, 1); put(hi, 1); put(lo, 1); put(d, k); sp();
    endtask
    // bounded wait on the programming flag
    task automatic wait_busy(input logic lv);
        int n;
        n = 0;
        while (write_busy !== lv && n < 1000) begin @(negedge sys_clk); n++; end
        if (n == 1000) begin error_cnt++; results(); end
    endtask
    task automatic results();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        // reset for two cycles
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (6) @(negedge sys_clk);
        // offset ff of page 1 wraps to 00
        st(); put(8'ha0, 1); put(8'h01, 1); put(8'hff, 1);
        put(8'h5a, 1); put(8'ha5, 1); sp();
        wait_busy(1);
        st(); put(8'ha0, 0); sp();
        wait_busy(0);
        rd(8'ha0, 8'h01, 8'hff, 8'h5a);
        rd(8'ha0, 8'h01, 8'h00, 8'ha5);
        // write protect: data refused
        write_protect = 1'b1;
        wr(8'ha0, 8'h01, 8'h00, 8'h33, 0);
        repeat (20) @(negedge sys_clk);
        check("busy", 8'h00, {7'h0, write_busy});
        rd(8'ha0, 8'h01, 8'h00, 8'ha5);
        write_protect = 1'b0;
        // foreign strap, type: no ack
        st(); put(8'ha8, 0); sp();
        st(); put(8'h90, 0); sp();
        rd(8'hb0, SEL_UID, 8'h00, UID[127:120]);
        wr(8'hb0, SEL_UID, 8'h00, 8'h00, 0);
        wr(8'hb0, SEL_PROT, 8'h00, {6'h0, PROT_HALF}, 1); wait_busy(0);
        wr(8'ha4, 8'h00, 8'h00, 8'h77, 0);
        wr(8'hb0, SEL_LOCK, 8'h00, 8'h01, 1); wait_busy(0);
        wr(8'hb0, SEL_ID, 8'h00, 8'h11, 0);
        strap = 1'b1;
        repeat (8) @(negedge sys_clk);
        rd(8'ha8, 8'h01, 8'hff, 8'h5a);
        results();
    end
endmodule
bind serial_eeprom_slave_port serial_eeprom_slave_port_checker #(.WRITE_COUNT(WRITE_COUNT)) u_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .write_protect(write_protect),
    .chip_select_strap(chip_select_strap), .write_busy(write_busy));
`default_nettype wire
